//--- ifd_instruction_field_decoder.sv
// instruction field decoder: format, opcode, operand select, traps
// Notes on behaviour
// - Two-bit format selector: 00 branch/set-high, 01 call, 10/11 all others.
// - Format 00 decodes opcode: 000 unimpl, 010 int, 100 set-high, 110 fp, 111 cp.
// - Reserved format-2 opcode, op3 or immediate-select patterns raise illegal-instruction trap.
// - Unused fields are ignored and never cause a trap.
// - Reserved fp or cp operation codes raise fp or cp exception, not illegal.
// - Format-3 operations other than fp/cp take second register when select is 0, immediate when 1.
// - The 13-bit immediate is sign-extended to 32 bits.
// - Call displacement is a 30-bit word offset, passed on without appended zero bits.
// - Register zero always reads as zero when selected as a source.
`default_nettype none
module ifd_instruction_field_decoder #(
	parameter logic [63:0] OP3_LEGAL_ARITH = ifd_pkg::OP3_ALL,
	parameter logic [63:0] OP3_LEGAL_MEM = ifd_pkg::OP3_ALL,
	parameter logic [63:0] OP3_FPOP = ifd_pkg::OP3_NONE,
	parameter logic [63:0] OP3_CPOP = ifd_pkg::OP3_NONE,
	parameter logic [63:0] OP3_NO_IMM = ifd_pkg::OP3_NONE
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// instruction from fetch
	input wire logic instr_valid_in,
	input wire logic [31:0] instr_word_in,
	// operation-code checks from the attached fp unit and coprocessor
	input wire logic fpu_opf_known_in,
	input wire logic cp_opc_known_in,
	// register file read port
	output logic [4:0] rs1_addr_out,
	output logic [4:0] rs2_addr_out,
	input wire logic [31:0] rs1_data_in,
	input wire logic [31:0] rs2_data_in,
	// decoded result to execute
	output ifd_pkg::ifd_dec_t dec_out
);
	ifd_pkg::ifd_dec_t dec_r;
	ifd_pkg::ifd_dec_t dec_nxt;

	wire logic [1:0] format_selector = instr_word_in[ifd_pkg::FSEL_HI:ifd_pkg::FSEL_LO];
	wire logic [2:0] format2_opcode = instr_word_in[ifd_pkg::F2OP_HI:ifd_pkg::F2OP_LO];
	wire logic [5:0] format3_opcode = instr_word_in[ifd_pkg::F3OP_HI:ifd_pkg::F3OP_LO];
	wire logic [4:0] dest_field = instr_word_in[ifd_pkg::RD_HI:ifd_pkg::RD_LO];
	wire logic [4:0] first_source_field = instr_word_in[ifd_pkg::RS1_HI:ifd_pkg::RS1_LO];
	wire logic [4:0] second_source_field = instr_word_in[ifd_pkg::RS2_HI:ifd_pkg::RS2_LO];
	wire logic imm_sel = instr_word_in[ifd_pkg::ISEL_BIT];
	wire logic [12:0] signed_immediate_field = instr_word_in[ifd_pkg::SIMM_HI:ifd_pkg::SIMM_LO];
	wire logic [21:0] branch_word_displacement = instr_word_in[ifd_pkg::BRANCH_WORD_DISPLACEMENT_HI:0];
	wire logic [29:0] call_word_displacement = instr_word_in[ifd_pkg::CALL_WORD_DISPLACEMENT_HI:0];

	wire logic is_f2 = (format_selector == ifd_pkg::FSEL_F2);
	wire logic is_call = (format_selector == ifd_pkg::FSEL_CALL);
	wire logic is_f3 = instr_word_in[ifd_pkg::FSEL_HI];
	wire logic is_arith = is_f3 && !instr_word_in[ifd_pkg::FSEL_LO];
	wire ifd_pkg::ifd_fmt_t fmt = is_f2 ? ifd_pkg::IFD_FMT_BR_SET_HIGH_IMMEDIATE :
		(is_call ? ifd_pkg::IFD_FMT_CALL : ifd_pkg::IFD_FMT_OTHER);

	wire logic f2_unimp = is_f2 && (format2_opcode == ifd_pkg::F2_UNIMP);
	wire logic f2_int = is_f2 && (format2_opcode == ifd_pkg::F2_INT_BR);
	wire logic f2_set_high_immediate = is_f2 && (format2_opcode == ifd_pkg::F2_SET_HIGH_IMMEDIATE);
	wire logic f2_fp = is_f2 && (format2_opcode == ifd_pkg::F2_FP_BR);
	wire logic f2_cp = is_f2 && (format2_opcode == ifd_pkg::F2_CP_BR);
	wire logic f2_known = f2_int || f2_set_high_immediate || f2_fp || f2_cp;
	wire ifd_pkg::ifd_f2op_t f2op = !is_f2 ? ifd_pkg::IFD_F2_NONE :
		f2_int ? ifd_pkg::IFD_F2_INT_BR :
		f2_set_high_immediate ? ifd_pkg::IFD_F2_SET_HIGH_IMMEDIATE :
		f2_fp ? ifd_pkg::IFD_F2_FP_BR :
		f2_cp ? ifd_pkg::IFD_F2_CP_BR : ifd_pkg::IFD_F2_UNIMP;

	// fp and cp operate codes go to their own exceptions
	wire logic is_fpop = is_f3 && OP3_FPOP[format3_opcode];
	wire logic is_cpop = is_f3 && OP3_CPOP[format3_opcode];
	wire logic fp_exc = is_fpop && !fpu_opf_known_in;
	wire logic cp_exc = is_cpop && !cp_opc_known_in;

	// reserved format-3 opcode and wrong immediate-select use
	wire logic [63:0] legal_tab = is_arith ? OP3_LEGAL_ARITH : OP3_LEGAL_MEM;
	wire logic op3_bad = is_f3 && !legal_tab[format3_opcode];
	wire logic uses_isel = is_f3 && !is_fpop && !is_cpop;
	wire logic isel_bad = uses_isel && imm_sel && OP3_NO_IMM[format3_opcode];
	// call ignores all, format 2 ignores op3/i, fp/cp ignores i
	wire logic illegal = (is_f2 && !f2_known) || op3_bad || isel_bad;

	assign rs1_addr_out = first_source_field;
	assign rs2_addr_out = second_source_field;
	wire logic [31:0] rs1_val = (first_source_field == ifd_pkg::REG_ZERO) ?
		ifd_pkg::WORD_ZERO : rs1_data_in;
	wire logic [31:0] rs2_val = (second_source_field == ifd_pkg::REG_ZERO) ?
		ifd_pkg::WORD_ZERO : rs2_data_in;

	wire logic [31:0] simm_ext = {{(ifd_pkg::WORD_W - ifd_pkg::SIMM_W)
		{signed_immediate_field[ifd_pkg::OPND_MSB]}}, signed_immediate_field};
	// second operand select, only for format-3 operations other than fp and cp
	wire logic [31:0] opnd2 = (uses_isel && imm_sel) ? simm_ext : rs2_val;
	wire logic [31:0] br_ext = {{(ifd_pkg::WORD_W - ifd_pkg::BRANCH_WORD_DISPLACEMENT_W - ifd_pkg::ALIGN_W)
		{branch_word_displacement[ifd_pkg::BRANCH_WORD_DISPLACEMENT_HI]}}, branch_word_displacement,
		ifd_pkg::ALIGN_ZERO};

	// next decoded word; flags only set for a valid instruction
	always_comb begin
		dec_nxt = dec_r;
		dec_nxt.valid = instr_valid_in;
		dec_nxt.fmt = fmt;
		dec_nxt.f2op = f2op;
		dec_nxt.format3_opcode = format3_opcode;
		dec_nxt.dest_field = dest_field;
		dec_nxt.first_source_field = first_source_field;
		dec_nxt.second_source_field = second_source_field;
		dec_nxt.imm_select = uses_isel && imm_sel;
		dec_nxt.operand1 = rs1_val;
		dec_nxt.operand2 = opnd2;
		dec_nxt.branch_word_displacement = br_ext;
		// 30-bit call word offset passed as is
		dec_nxt.call_word_displacement = call_word_displacement;
		dec_nxt.upper_constant_field = branch_word_displacement;
		dec_nxt.illegal_trap = instr_valid_in && illegal;
		dec_nxt.fp_exception = instr_valid_in && fp_exc;
		dec_nxt.cp_exception = instr_valid_in && cp_exc;
	end

	// output register
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			dec_r <= '0;
		end else begin
			dec_r <= dec_nxt;
		end
	end

	assign dec_out = dec_r;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	sequence s_valid_in;
		instr_valid_in;
	endsequence
	sequence s_f2_in;
		s_valid_in ##0 is_f2;
	endsequence

	a_call_format: assert property (s_valid_in ##0 is_call |=> dec_out.fmt == ifd_pkg::IFD_FMT_CALL && !dec_out.illegal_trap) else $error("call not classified");
	a_fp_branch_op: assert property (s_f2_in ##0 format2_opcode == ifd_pkg::F2_FP_BR |=> dec_out.f2op == ifd_pkg::IFD_F2_FP_BR) else $error("fp branch not decoded");
	a_unimp_trap: assert property (s_f2_in ##0 (format2_opcode[0] ^ (format2_opcode == ifd_pkg::F2_CP_BR) || format2_opcode == ifd_pkg::F2_UNIMP) |=> dec_out.illegal_trap) else $error("reserved format-2 opcode not trapped");
	a_call_no_trap: assert property (dec_out.valid && dec_out.fmt == ifd_pkg::IFD_FMT_CALL |-> !dec_out.illegal_trap && !dec_out.fp_exception) else $error("call raised a trap");
	a_fp_not_illegal: assert property (dec_out.fp_exception || dec_out.cp_exception |-> !dec_out.illegal_trap || $past(op3_bad)) else $error("fp or cp exception also trapped");
	a_imm_operand: assert property (s_valid_in ##0 uses_isel && imm_sel |=> dec_out.operand2 == {{19{$past(instr_word_in[12])}}, $past(instr_word_in[12:0])}) else $error("immediate operand wrong");
	a_sign_extend: assert property (dec_out.imm_select |-> dec_out.operand2[31:13] == {19{dec_out.operand2[12]}}) else $error("immediate not sign-extended");
	a_branch_disp: assert property (s_valid_in |=> dec_out.branch_word_displacement == {{8{$past(instr_word_in[21])}}, $past(instr_word_in[21:0]), 2'b00}) else $error("branch offset wrong");
	a_call_disp: assert property (s_valid_in |=> dec_out.call_word_displacement == $past(instr_word_in[29:0])) else $error("call offset wrong");
	a_reg_zero: assert property (s_valid_in ##0 first_source_field == 5'h00 |=> dec_out.operand1 == 32'h0000_0000) else $error("register zero not zero");
	a_field_pos: assert property (s_valid_in |=> dec_out.dest_field == $past(instr_word_in[29:25]) && dec_out.first_source_field == $past(instr_word_in[18:14])) else $error("field slice wrong");
endmodule : ifd_instruction_field_decoder
`default_nettype wire

//--- ifd_pkg.sv
// constants, field layout and decoded-word types of the instruction field decoder
`default_nettype none
package ifd_pkg;
	// field positions inside the instruction word
	localparam int FSEL_HI = 31;
	localparam int FSEL_LO = 30;
	localparam int RD_HI = 29;
	localparam int RD_LO = 25;
	localparam int F2OP_HI = 24;
	localparam int F2OP_LO = 22;
	localparam int F3OP_HI = 24;
	localparam int F3OP_LO = 19;
	localparam int RS1_HI = 18;
	localparam int RS1_LO = 14;
	localparam int ISEL_BIT = 13;
	localparam int RS2_HI = 4;
	localparam int RS2_LO = 0;
	localparam int SIMM_HI = 12;
	localparam int SIMM_LO = 0;
	localparam int BRANCH_WORD_DISPLACEMENT_HI = 21;
	localparam int CALL_WORD_DISPLACEMENT_HI = 29;
	localparam int OPND_MSB = 12;
	localparam int WORD_W = 32;
	localparam int SIMM_W = 13;
	localparam int BRANCH_WORD_DISPLACEMENT_W = 22;
	localparam int CALL_WORD_DISPLACEMENT_W = 30;
	localparam int ALIGN_W = 2;
	// format selector codes; any code with the top bit set is format 3
	localparam logic [1:0] FSEL_F2 = 2'h0;
	localparam logic [1:0] FSEL_CALL = 2'h1;
	// format-2 opcode codes
	localparam logic [2:0] F2_UNIMP = 3'h0;
	localparam logic [2:0] F2_INT_BR = 3'h2;
	localparam logic [2:0] F2_SET_HIGH_IMMEDIATE = 3'h4;
	localparam int F2_FP_BR_I = 6;
	localparam logic [2:0] F2_FP_BR = 3'h6;
	localparam logic [2:0] F2_CP_BR = 3'h7;
	localparam logic [4:0] REG_ZERO = 5'h00;
	localparam logic [1:0] ALIGN_ZERO = 2'h0;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// default op3 tables: every code legal, none floating-point or coprocessor
	localparam logic [63:0] OP3_ALL = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [63:0] OP3_NONE = 64'h0000_0000_0000_0000;

	// instruction format, one-hot
	typedef enum logic [2:0] {
		IFD_FMT_BR_SET_HIGH_IMMEDIATE = 3'b001,
		IFD_FMT_CALL = 3'b010,
		IFD_FMT_OTHER = 3'b100
	} ifd_fmt_t;

	// format-2 opcode class, one-hot
	typedef enum logic [5:0] {
		IFD_F2_NONE = 6'b000001,
		IFD_F2_UNIMP = 6'b000010,
		IFD_F2_INT_BR = 6'b000100,
		IFD_F2_SET_HIGH_IMMEDIATE = 6'b001000,
		IFD_F2_FP_BR = 6'b010000,
		IFD_F2_CP_BR = 6'b100000
	} ifd_f2op_t;

	// decoded instruction handed to the execute stage
	typedef struct packed {
		logic valid;
		ifd_fmt_t fmt;
		ifd_f2op_t f2op;
		logic [5:0] format3_opcode;
		logic [4:0] dest_field;
		logic [4:0] first_source_field;
		logic [4:0] second_source_field;
		logic imm_select;
		logic [31:0] operand1;
		logic [31:0] operand2;
		logic [31:0] branch_word_displacement;
		logic [29:0] call_word_displacement;
		logic [21:0] upper_constant_field;
		logic illegal_trap;
		logic fp_exception;
		logic cp_exception;
	} ifd_dec_t;
endpackage : ifd_pkg
`default_nettype wire

//--- ifd_unused_placeholder_none.sv
// intentionally empty compilation unit
`default_nettype none
`default_nettype wire

//--- ifd_regfile_model.sv
// register file and fp/cp opcode checker model standing beside the decoder
`default_nettype none
module ifd_regfile_model (
	// instruction currently presented
	input wire logic [31:0] instr_word_in,
	// register file read port
	input wire logic [4:0] rs1_addr_in,
	input wire logic [4:0] rs2_addr_in,
	output logic [31:0] rs1_data_out,
	output logic [31:0] rs2_data_out,
	// attached unit opcode checks
	output logic fpu_known_out,
	output logic cp_known_out
);
	// register zero reads nonzero here so the decoder must force it
	assign rs1_data_out = {rs1_addr_in, 22'h2AAAAA, rs1_addr_in};
	assign rs2_data_out = {rs2_addr_in, 22'h2AAAAA, rs2_addr_in};
	// one reserved fp code and one reserved cp code
	assign fpu_known_out = (instr_word_in[13:5] != 9'h1FF);
	assign cp_known_out = (instr_word_in[13:5] != 9'h1FE);
endmodule : ifd_regfile_model
`default_nettype wire

//--- tb_instruction_field_decoder.sv
// self-checking testbench of the instruction field decoder
`default_nettype none
module tb_instruction_field_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic v = 1'b0;
	logic [31:0] w = 32'h0000_0000;
	logic fk, ck;
	logic [4:0] a1, a2;
	logic [31:0] d1, d2;
	ifd_pkg::ifd_dec_t dec;
	int error_cnt = 0;
	int check_count = 0;
	logic [5:0] f2tab [8] = '{6'h02, 6'h02, 6'h04, 6'h02, 6'h08, 6'h02, 6'h10, 6'h20};
	// op3 3F illegal in arithmetic, 34 fp, 36 cp, 01 refuses an immediate
	ifd_instruction_field_decoder #(.OP3_LEGAL_ARITH(64'h7FFF_FFFF_FFFF_FFFF),
		.OP3_FPOP(64'h0010_0000_0000_0000), .OP3_CPOP(64'h0040_0000_0000_0000),
		.OP3_NO_IMM(64'h0000_0000_0000_0002)) ifd_instruction_field_decoder_i (
		.clk_in(clk_in), .srst_in(srst_in), .instr_valid_in(v), .instr_word_in(w),
		.fpu_opf_known_in(fk), .cp_opc_known_in(ck), .rs1_addr_out(a1), .rs2_addr_out(a2),
		.rs1_data_in(d1), .rs2_data_in(d2), .dec_out(dec));
	ifd_regfile_model ifd_regfile_model_i (.instr_word_in(w), .rs1_addr_in(a1),
		.rs2_addr_in(a2), .rs1_data_out(d1), .rs2_data_out(d2), .fpu_known_out(fk),
		.cp_known_out(ck));
	// clock at 40 ns
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// present one word at a falling edge, result visible one edge later
	task automatic apply(input logic [31:0] iw, input logic iv);
		v = iv;
		w = iw;
		@(negedge clk_in);
	endtask : apply
	function automatic logic [31:0] f3(logic [1:0] fs, logic [5:0] o3, logic [4:0] r1,
		logic i, logic [12:0] lo);
		return {fs, 5'h0A, o3, r1, i, lo};
	endfunction : f3
	task automatic test_formats;
		for (int k = 0; k < 8; k++) begin
			apply({2'h0, 5'h1F, k[2:0], 22'h3FFFFF}, 1'b1);
			check(dec.f2op, f2tab[k]);
			check(dec.illegal_trap, f2tab[k] == 6'h02);
			check(dec.fmt, 32'h1);
		end
		apply(32'h6ABC_DEF1, 1'b1);
		check(dec.fmt, 32'h2);
		check(dec.call_word_displacement, 32'h2ABC_DEF1);
		check(dec.illegal_trap, 32'h0);
		for (int k = 2; k < 4; k++) begin
			apply(f3(k[1:0], 6'h00, 5'h01, 1'b0, 13'h0002), 1'b1);
			check(dec.fmt, 32'h4);
			check(dec.f2op, 32'h1);
		end
		$display("test_formats done");
	endtask : test_formats
	task automatic test_operands;
		apply(f3(2'h2, 6'h00, 5'h00, 1'b0, 13'h0003), 1'b1);
		check(dec.operand1, 32'h0);
		check(dec.operand2, {5'h03, 22'h2AAAAA, 5'h03});
		check({dec.dest_field, dec.format3_opcode}, 32'h280);
		apply(f3(2'h2, 6'h15, 5'h05, 1'b1, 13'h1000), 1'b1);
		check(dec.operand1, {5'h05, 22'h2AAAAA, 5'h05});
		check(dec.operand2, 32'hFFFF_F000);
		check(dec.first_source_field, 32'h05);
		apply(f3(2'h2, 6'h00, 5'h00, 1'b1, 13'h0FFF), 1'b1);
		check(dec.operand2, 32'h0000_0FFF);
		apply(32'h0880_0001, 1'b1);
		check(dec.branch_word_displacement, 32'h0000_0004);
		apply(32'h08A0_0001, 1'b1);
		check(dec.branch_word_displacement, 32'hFF80_0004);
		apply(32'h0123_4567, 1'b1);
		check(dec.upper_constant_field, 32'h0023_4567);
		$display("test_operands done");
	endtask : test_operands
	task automatic test_traps;
		apply(f3(2'h2, 6'h3F, 5'h01, 1'b0, 13'h0000), 1'b1);
		check(dec.illegal_trap, 32'h1);
		apply(f3(2'h3, 6'h3F, 5'h01, 1'b0, 13'h0000), 1'b1);
		check(dec.illegal_trap, 32'h0);
		apply(f3(2'h2, 6'h01, 5'h01, 1'b1, 13'h0000), 1'b1);
		check(dec.illegal_trap, 32'h1);
		apply(f3(2'h2, 6'h34, 5'h01, 1'b1, 13'h1FE0), 1'b1);
		check({dec.illegal_trap, dec.fp_exception, dec.cp_exception}, 32'h2);
		check(dec.imm_select, 32'h0);
		apply(f3(2'h2, 6'h36, 5'h01, 1'b1, 13'h1FC0), 1'b1);
		check({dec.illegal_trap, dec.fp_exception, dec.cp_exception}, 32'h1);
		apply(f3(2'h2, 6'h34, 5'h01, 1'b0, 13'h1FC0), 1'b1);
		check(dec.fp_exception, 32'h0);
		apply(f3(2'h2, 6'h3F, 5'h01, 1'b0, 13'h0000), 1'b0);
		check({dec.valid, dec.illegal_trap}, 32'h0);
		$display("test_traps done");
	endtask : test_traps
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done
	// reset for two cycles, then run each scenario
	initial begin
		repeat (2) @(negedge clk_in);
		// whole decoded word must be zero after reset; an unknown bit also fails
		check({31'h0, |dec}, 32'h0);
		srst_in = 1'b0;
		test_formats();
		test_operands();
		test_traps();
		test_done();
	end
endmodule : tb_instruction_field_decoder
`default_nettype wire
